/* hdl/afc_pkg.sv */
// constants and types for the converter frame and state controller
package afc_pkg;

   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   // conversion time on the internal clock, plain default
   localparam int CONV_TIME_NS = 700;
   localparam int CONV_CYCLES = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // delay from reset release to acquire, application reset
   localparam int SOFT_RESET_EXIT_DELAY_NS = 1000;
   localparam int SOFT_EXIT_CYCLES =
      (SOFT_RESET_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // delay from reset release to acquire, power-on clear
   localparam int POR_EXIT_DELAY_NS = 20000;
   localparam int POR_EXIT_CYCLES = (POR_EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int DELAY_W = 16;
   localparam logic [DELAY_W-1:0] CONV_COUNT = DELAY_W'(CONV_CYCLES - 1);
   localparam logic [DELAY_W-1:0] SOFT_EXIT_COUNT = DELAY_W'(SOFT_EXIT_CYCLES);
   localparam logic [DELAY_W-1:0] POR_EXIT_COUNT = DELAY_W'(POR_EXIT_CYCLES);
   localparam logic [DELAY_W-1:0] DELAY_ZERO = 16'h0000;

   // ----------------------------------------
   // frame layout
   // ----------------------------------------
   localparam int WORD_BITS = 32;
   localparam int EDGE_W = 6;
   localparam logic [EDGE_W-1:0] EDGE_ZERO = 6'h00;
   localparam logic [EDGE_W-1:0] EDGE_ONE = 6'h01;
   localparam logic [EDGE_W-1:0] FULL_FRAME_EDGES = 6'h20;
   localparam logic [EDGE_W-1:0] EDGE_SATURATE = 6'h21;
   localparam logic [WORD_BITS-1:0] IDLE_COMMAND = 32'h0000_0000;
   localparam logic [WORD_BITS-1:0] EMPTY_WORD = 32'h0000_0000;
   localparam int FIFO_DEPTH = 16;

   // frame classes
   localparam logic [1:0] CLASS_NONE = 2'h0;
   localparam logic [1:0] CLASS_SHORT = 2'h1;
   localparam logic [1:0] CLASS_OPTIMAL = 2'h2;
   localparam logic [1:0] CLASS_LONG = 2'h3;

   // operating states
   typedef enum logic [2:0] {
      ST_RESET = 3'b001,
      ST_ACQ = 3'b010,
      ST_CONV = 3'b100
   } afc_state_type;

endpackage

/* hdl/afc_sync.sv */
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/100ps
module afc_sync #(
   parameter int WIDTH = 4
) (
   input wire logic ref_clk_in, // system clock
   input wire logic resetn_in, // synchronous reset, active low
   input wire logic [WIDTH-1:0] async_in, // pins from outside the domain
   output logic [WIDTH-1:0] sync_out // synchronised levels
);
   logic [WIDTH-1:0] stage1;

   // first stage feeds only the second
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         stage1 <= '0;
         sync_out <= '0;
      end else begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

/* hdl/afc_fifo.sv */
// result fifo between conversion end and frame load
`timescale 1ns/100ps
module afc_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input wire logic ref_clk_in, // system clock
   input wire logic resetn_in, // synchronous reset, active low
   input wire logic flush_in, // drop all entries
   input wire logic in_valid_in, // write request
   output logic in_ready_out, // room for a word
   input wire logic [WIDTH-1:0] in_data_in, // write data
   output logic out_valid_out, // word available
   input wire logic out_ready_in, // read acknowledge
   output logic [WIDTH-1:0] out_data_out // head word
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
   localparam logic [AW:0] CNT_ONE = (AW+1)'(1);
   localparam logic [AW-1:0] PTR_ONE = AW'(1);
   localparam logic [AW-1:0] PTR_LAST = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;

   // handshake decode
   wire push = in_valid_in && in_ready_out;
   wire pop = out_valid_out && out_ready_in;
   wire [AW-1:0] next_wr = (wr_ptr == PTR_LAST) ? '0 : wr_ptr + PTR_ONE;
   wire [AW-1:0] next_rd = (rd_ptr == PTR_LAST) ? '0 : rd_ptr + PTR_ONE;

   assign in_ready_out = (count != CNT_FULL);
   assign out_valid_out = (count != '0);
   assign out_data_out = mem[rd_ptr];

   // pointers and fill level
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in || flush_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) wr_ptr <= next_wr;
         if (pop) rd_ptr <= next_rd;
         if (push && !pop) count <= count + CNT_ONE;
         else if (pop && !push) count <= count - CNT_ONE;
      end
   end

   // storage write
   always_ff @(posedge ref_clk_in) begin
      if (push) mem[wr_ptr] <= in_data_in;
   end
endmodule

/* hdl/afc_frame_ctrl.sv */
// serial frame handling and operating-state control of the converter
//
// Behaviour
// - reset kind bit picks application or power-on
// - application reset: defaults, ready low, lanes off
// - release with select and clock low, then acquire
// - reset high; select line alone picks state
// - acquire after power-up, reset and conversion
// - reset fall to reset; select rise converts
// - conversion timed internally, select ignored meanwhile
// - frame from select fall to select rise
// - frame open: ready low, clear, load, idle
// - capture edge: count and shift input in
// - launch edge: drive transmit msb on lanes
// - frame close: lanes off, decode, ready low
// - exactly 32 edges: full word is command
// - short frame: no command, output bits valid
// - long frame: last 32 bits are command
// - command takes effect at closing edge
`timescale 1ns/100ps
module afc_frame_ctrl
   import afc_pkg::*;
#(
   parameter int LANES = 2
) (
   input wire logic ref_clk_in, // system clock, 100 MHz
   input wire logic resetn_in, // synchronous reset, active low
   input wire logic rst_pin_n_in, // host reset pin, active low
   input wire logic convert_start_select_in, // host select pin
   input wire logic sclk_in, // host serial clock pin
   input wire logic sdi_in, // host serial data pin
   input wire logic reset_kind_select_in, // 1 application, 0 power-on
   input wire logic [LANES-1:0] lane_select_in, // lanes used for output
   input wire logic [WORD_BITS-1:0] conv_result_in, // result word at conversion end
   output logic [LANES-1:0] serial_out_lanes_out, // serial output data
   output logic [LANES-1:0] serial_out_oe_out, // lane drive enable
   output logic ready_strobe_out, // ready output
   output logic [WORD_BITS-1:0] cmd_word_out, // decoded command word
   output logic cmd_valid_out, // command pulse at frame close
   output logic [1:0] frame_class_out, // class of last frame
   output logic conv_busy_out, // conversion running
   output logic config_reset_out, // config registers to defaults
   output logic power_reset_out // whole device cleared
);

   // ----------------------------------------
   // pin synchronisation and edges
   // ----------------------------------------
   logic s_rstn;
   logic s_cs;
   logic s_sclk;
   logic s_sdi;
   logic cs_d;
   logic sclk_d;

   afc_sync #(.WIDTH(4)) u_sync (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .async_in({rst_pin_n_in, convert_start_select_in, sclk_in, sdi_in}),
      .sync_out({s_rstn, s_cs, s_sclk, s_sdi})
   );

   // delayed copies for edge finding
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         cs_d <= 1'b0;
         sclk_d <= 1'b0;
      end else begin
         cs_d <= s_cs;
         sclk_d <= s_sclk;
      end
   end

   wire cs_rise = s_cs && !cs_d;
   wire cs_fall = !s_cs && cs_d;
   wire sclk_rise = s_sclk && !sclk_d;
   wire sclk_fall = !s_sclk && sclk_d;

   // ----------------------------------------
   // state and timing
   // ----------------------------------------
   afc_state_type state;
   afc_state_type next_state;
   logic [DELAY_W-1:0] delay_cnt;
   logic [DELAY_W-1:0] next_delay;
   logic reset_kind;
   logic frame_active;
   logic fill_ready;

   // state events
   wire delay_done = (delay_cnt == DELAY_ZERO);
   wire exit_ok = s_rstn && !s_cs && !s_sclk;
   wire conv_start = (state == ST_ACQ) && s_rstn && cs_rise;
   wire conv_end = (state == ST_CONV) && s_rstn && delay_done && fill_ready;
   wire frame_open = (state == ST_ACQ) && s_rstn && cs_fall;
   wire frame_close = frame_active && conv_start;
   wire enter_reset = (state != ST_RESET) && !s_rstn;
   wire next_kind = enter_reset ? reset_kind_select_in : reset_kind;

   // state transitions
   always_comb begin
      next_state = state;
      if (!s_rstn) begin
         next_state = ST_RESET;
      end else begin
         unique case (state)
            ST_RESET: begin
               if (exit_ok && delay_done) next_state = ST_ACQ;
            end
            ST_ACQ: begin
               if (cs_rise) next_state = ST_CONV;
            end
            ST_CONV: begin
               if (delay_done && fill_ready) next_state = ST_ACQ;
            end
         endcase
      end
   end

   // exit and conversion delay counter
   always_comb begin
      next_delay = delay_cnt;
      if (!s_rstn) begin
         next_delay = next_kind ? SOFT_EXIT_COUNT : POR_EXIT_COUNT;
      end else if (conv_start) begin
         next_delay = CONV_COUNT;
      end else if (!delay_done && ((state == ST_CONV) || (state == ST_RESET && exit_ok))) begin
         next_delay = delay_cnt - 16'h0001;
      end
   end

   // state registers; power-up behaves as a power-on clear
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         state <= ST_RESET;
         delay_cnt <= POR_EXIT_COUNT;
         reset_kind <= 1'b0;
      end else begin
         state <= next_state;
         delay_cnt <= next_delay;
         reset_kind <= next_kind;
      end
   end

   // reset kind outputs and busy flag
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         config_reset_out <= 1'b0;
         power_reset_out <= 1'b1;
         conv_busy_out <= 1'b0;
      end else begin
         config_reset_out <= (next_state == ST_RESET) && next_kind;
         power_reset_out <= (next_state == ST_RESET) && !next_kind;
         conv_busy_out <= (next_state == ST_CONV);
      end
   end

   // ----------------------------------------
   // result fifo
   // ----------------------------------------
   logic fifo_valid;
   logic [WORD_BITS-1:0] fifo_data;

   afc_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
      .ref_clk_in(ref_clk_in),
      .resetn_in(resetn_in),
      .flush_in(power_reset_out),
      .in_valid_in((state == ST_CONV) && delay_done),
      .in_ready_out(fill_ready),
      .in_data_in(conv_result_in),
      .out_valid_out(fifo_valid),
      .out_ready_in(frame_open),
      .out_data_out(fifo_data)
   );

   wire [WORD_BITS-1:0] load_word = fifo_valid ? fifo_data : EMPTY_WORD;

   // ----------------------------------------
   // shift registers and edge counter
   // ----------------------------------------
   logic [EDGE_W-1:0] edge_cnt;
   logic [WORD_BITS-1:0] rx_shift;
   logic [WORD_BITS-1:0] tx_shift_word;
   logic sdo_bit;

   wire capture = frame_active && sclk_rise;
   wire launch = frame_active && sclk_fall;
   wire edge_sat = (edge_cnt == EDGE_SATURATE);
   wire full_frame = (edge_cnt >= FULL_FRAME_EDGES);

   // frame flag and capture side
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         frame_active <= 1'b0;
         edge_cnt <= EDGE_ZERO;
         rx_shift <= '0;
      end else begin
         if (frame_open) frame_active <= 1'b1;
         else if (conv_start || !s_rstn) frame_active <= 1'b0;
         if (frame_open) edge_cnt <= EDGE_ZERO;
         else if (capture && !edge_sat) edge_cnt <= edge_cnt + EDGE_ONE;
         if (capture) rx_shift <= {rx_shift[WORD_BITS-2:0], s_sdi};
      end
   end

   // launch side; mode-0 style, msb valid from frame open
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         tx_shift_word <= EMPTY_WORD;
         sdo_bit <= 1'b0;
      end else if (frame_open) begin
         tx_shift_word <= load_word;
         sdo_bit <= load_word[WORD_BITS-1];
      end else if (launch) begin
         tx_shift_word <= {tx_shift_word[WORD_BITS-2:0], 1'b0};
         sdo_bit <= tx_shift_word[WORD_BITS-2];
      end
   end

   // lane drive and enables
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         serial_out_lanes_out <= '0;
         serial_out_oe_out <= '0;
      end else begin
         serial_out_lanes_out <= {LANES{sdo_bit}} & lane_select_in;
         if (!s_rstn || conv_start) serial_out_oe_out <= '0;
         else if (frame_open) serial_out_oe_out <= lane_select_in;
      end
   end

   // ----------------------------------------
   // ready output and command hand-off
   // ----------------------------------------
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         ready_strobe_out <= 1'b0;
      end else if (next_state == ST_RESET) begin
         ready_strobe_out <= 1'b0;
      end else if ((state != ST_ACQ) && (next_state == ST_ACQ)) begin
         ready_strobe_out <= 1'b1;
      end else if (frame_open || conv_start) begin
         ready_strobe_out <= 1'b0;
      end
   end

   // command word: idle at open, decoded at close
   always_ff @(posedge ref_clk_in) begin
      if (!resetn_in) begin
         cmd_word_out <= IDLE_COMMAND;
         cmd_valid_out <= 1'b0;
         frame_class_out <= CLASS_NONE;
      end else begin
         cmd_valid_out <= 1'b0;
         if (frame_open) begin
            cmd_word_out <= IDLE_COMMAND;
         end else if (frame_close) begin
            if (full_frame) begin
               cmd_word_out <= rx_shift;
               cmd_valid_out <= 1'b1;
            end else begin
               cmd_word_out <= IDLE_COMMAND;
            end
            frame_class_out <= !full_frame ? CLASS_SHORT :
               (edge_cnt == FULL_FRAME_EDGES) ? CLASS_OPTIMAL : CLASS_LONG;
         end
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!resetn_in);

   a_reset_kind_out: assert property (enter_reset |=>
      config_reset_out == $past(reset_kind_select_in) && power_reset_out != config_reset_out)
      else $error("reset kind output wrong");
   a_reset_quiet: assert property (state == ST_RESET |->
      !ready_strobe_out && serial_out_oe_out == '0)
      else $error("ready or lanes active in reset");
   a_reset_exit: assert property (state == ST_RESET && exit_ok && delay_done |=>
      state == ST_ACQ ##1 ready_strobe_out)
      else $error("no acquire after reset exit");
   a_pin_reset: assert property (!s_rstn |=> state == ST_RESET)
      else $error("reset pin not obeyed");
   a_conv_hold: assert property (state == ST_CONV && s_rstn && !delay_done |=>
      state == ST_CONV)
      else $error("conversion cut short");
   a_conv_end: assert property (conv_end |=> state == ST_ACQ ##1 ready_strobe_out)
      else $error("no acquire after conversion");
   a_frame_open: assert property (frame_open |=> edge_cnt == EDGE_ZERO &&
      !ready_strobe_out && cmd_word_out == IDLE_COMMAND && tx_shift_word == $past(load_word))
      else $error("frame open effects missing");
   a_capture_edge: assert property (capture && !edge_sat && !frame_open |=>
      edge_cnt == $past(edge_cnt) + EDGE_ONE && rx_shift[0] == $past(s_sdi))
      else $error("capture edge not counted");
   a_launch_msb: assert property (launch && !frame_open |=>
      sdo_bit == $past(tx_shift_word[WORD_BITS-2]))
      else $error("launch bit wrong");
   a_frame_close: assert property (frame_close |=> serial_out_oe_out == '0 &&
      !ready_strobe_out && state == ST_CONV)
      else $error("frame close effects missing");
   a_full_cmd: assert property (frame_close && full_frame |=>
      cmd_valid_out && cmd_word_out == $past(rx_shift) ##1 !cmd_valid_out)
      else $error("full frame command lost");
   a_short_nop: assert property (frame_close && !full_frame |=>
      !cmd_valid_out && cmd_word_out == IDLE_COMMAND && frame_class_out == CLASS_SHORT)
      else $error("short frame produced command");

endmodule

/* tb/afc_host.sv */
// host controller model driving the converter's serial pins
`timescale 1ns/100ps
module afc_host (
   input wire logic sdo_in, // serial data from the device
   input wire logic ready_in, // device ready output
   output logic rst_pin_n_out, // reset pin, active low
   output logic cs_out, // convert start and select
   output logic sclk_out, // serial clock, still outside frames
   output logic sdi_out // serial data to the device
);
   localparam int HALF_NS = 80;
   localparam int MIN_RESET_LOW_CYCLES = 10;
   // idle levels: select and clock low so reset exit is legal
   initial begin
      rst_pin_n_out = 1'b1;
      cs_out = 1'b0;
      sclk_out = 1'b0;
      sdi_out = 1'b0;
   end
   // reset pin held low for the minimum time, select dropped after
   task automatic reset_hold();
      rst_pin_n_out = 1'b0;
      #10 cs_out = 1'b0;
      #(MIN_RESET_LOW_CYCLES * 10);
   endtask
   task automatic reset_release();
      rst_pin_n_out = 1'b1;
   endtask
   // bare select rise: starts a conversion
   task automatic start();
      cs_out = 1'b1;
   endtask
   // select pulse during a conversion, meant to be ignored
   task automatic glitch();
      cs_out = 1'b0;
      #40 cs_out = 1'b1;
   endtask
   // one frame of n bits, msb first, mode 0; final bits carry the command
   task automatic xfer(input int n, input logic [63:0] tx, output logic [63:0] rx);
      rx = 64'h0;
      cs_out = 1'b0;
      #HALF_NS;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_out = tx[i];
         #HALF_NS sclk_out = 1'b1;
         rx = {rx[62:0], sdo_in};
         #HALF_NS sclk_out = 1'b0;
      end
      sdi_out = ~sdi_out;
      #HALF_NS cs_out = 1'b1;
   endtask
   // wait for ready rise before any new operation
   task automatic wait_ready(input int bound, output int n);
      n = 0;
      while (ready_in !== 1'b1 && n < bound) begin
         #10 n++;
      end
   endtask
endmodule

/* tb/testbench.sv */
// self-checking bench for the converter frame and state controller
`timescale 1ns/100ps
module testbench;
   import afc_pkg::*;
   logic ref_clk_in = 1'b0;
   logic resetn_in = 1'b0;
   logic kind = 1'b0;
   logic [1:0] lane_sel = 2'h1;
   logic [WORD_BITS-1:0] result = 32'h0000_0000;
   logic rst_n, cs, sclk, sdi, ready, cmd_valid, busy, cfg_rst, pwr_rst;
   logic [1:0] lanes, oe, fclass;
   logic [WORD_BITS-1:0] cmd_word;
   logic [WORD_BITS-1:0] expq[$];
   logic [63:0] rx;
   int n_fail = 0;
   int num_checks = 0;
   int n_valid = 0;
   int cyc = 0;
   int wait_n;
   // time of the select rise that started the running conversion
   time t_cs = 0;
   always #5 ref_clk_in = ~ref_clk_in;

   afc_frame_ctrl #(.LANES(2)) dut_u (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
      .rst_pin_n_in(rst_n), .convert_start_select_in(cs), .sclk_in(sclk), .sdi_in(sdi),
      .reset_kind_select_in(kind), .lane_select_in(lane_sel), .conv_result_in(result),
      .serial_out_lanes_out(lanes), .serial_out_oe_out(oe), .ready_strobe_out(ready),
      .cmd_word_out(cmd_word), .cmd_valid_out(cmd_valid), .frame_class_out(fclass),
      .conv_busy_out(busy), .config_reset_out(cfg_rst), .power_reset_out(pwr_rst));
   // a released lane shows the inverse of its last bit, so sampling it is caught
   afc_host host_u (.sdo_in(oe[0] ? lanes[0] : !lanes[0]), .ready_in(ready), .rst_pin_n_out(rst_n),
      .cs_out(cs), .sclk_out(sclk), .sdi_out(sdi));

   // command pulse counter and hang guard
   always @(posedge ref_clk_in) begin
      cyc <= cyc + 1;
      if (cmd_valid === 1'b1) n_valid <= n_valid + 1;
      if (cyc == 12000) begin
         n_fail = n_fail + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      num_checks++;
      if (ok !== 1'b1) begin
         n_fail++;
         $display("Error at %0t: %s", $time, msg);
      end
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk_in);
      #1;
   endtask
   // conversion: result word queued, ready rises after the internal time
   task automatic run_conv();
      expq.push_back(result);
      host_u.wait_ready(200, wait_n);
      check($time - t_cs >= CONV_CYCLES * CLK_PERIOD_NS && wait_n < 200,
         "conversion length");
      check(busy === 1'b0, "acquire after conversion");
   endtask
   task automatic t_por_exit();
      check(pwr_rst === 1'b1 && ready === 1'b0, "power-on reset state");
      host_u.wait_ready(2300, wait_n);
      check(wait_n >= POR_EXIT_CYCLES && wait_n < 2300, "power-on exit");
      check(pwr_rst === 1'b0, "power reset ends");
      result = 32'ha1b2_c3d4;
      host_u.start();
      t_cs = $time;
      settle(6);
      check(busy === 1'b1 && ready === 1'b0, "select rise converts");
      run_conv();
   endtask
   task automatic t_optimal();
      logic [WORD_BITS-1:0] w;
      int v0;
      w = expq.pop_front();
      v0 = n_valid;
      result = 32'h5a3c_0f12;
      fork
         host_u.xfer(32, 64'h0000_0000_c3a5_1e07, rx);
         begin
            settle(20);
            check(oe === 2'h1 && ready === 1'b0 && cmd_word === IDLE_COMMAND,
               "frame open outputs");
            check(lanes[1] === 1'b0, "unselected lane");
         end
      join
      t_cs = $time;
      settle(8);
      check(rx[31:0] === w, "shifted out word");
      check(cmd_word === 32'hc3a5_1e07 && fclass === CLASS_OPTIMAL, "optimal");
      check(n_valid == v0 + 1, "one command pulse");
      check(oe === 2'h0 && ready === 1'b0 && busy === 1'b1, "frame close");
      run_conv();
   endtask
   task automatic t_long();
      logic [WORD_BITS-1:0] w;
      int v0;
      w = expq.pop_front();
      v0 = n_valid;
      result = 32'h8f0f_7e81;
      host_u.xfer(40, 64'h0000_00e7_9d3b_6c05, rx);
      t_cs = $time;
      settle(8);
      check(rx[39:8] === w, "long frame data");
      check(cmd_word === 32'h9d3b_6c05 && fclass === CLASS_LONG, "long");
      check(n_valid == v0 + 1, "long command pulse");
      host_u.glitch();
      settle(8);
      check(busy === 1'b1 && oe === 2'h0 && ready === 1'b0, "select ignored");
      run_conv();
   endtask
   task automatic t_short();
      logic [WORD_BITS-1:0] w;
      int v0;
      w = expq.pop_front();
      v0 = n_valid;
      lane_sel = 2'h3;
      fork
         host_u.xfer(8, 64'h0000_0000_0000_00ff, rx);
         begin
            settle(20);
            check(oe === 2'h3 && lanes === {2{w[31]}}, "both lanes driven");
         end
      join
      t_cs = $time;
      settle(8);
      check(rx[7:0] === w[31:24], "short frame leading bits");
      check(cmd_word === IDLE_COMMAND && fclass === CLASS_SHORT, "short");
      check(n_valid == v0, "no command pulse");
      run_conv();
   endtask
   task automatic t_app_reset();
      kind = 1'b1;
      host_u.reset_hold();
      settle(2);
      check(cfg_rst === 1'b1 && pwr_rst === 1'b0, "application reset");
      check(ready === 1'b0 && oe === 2'h0, "reset outputs");
      host_u.reset_release();
      host_u.wait_ready(300, wait_n);
      check(wait_n >= SOFT_EXIT_CYCLES && wait_n < 300, "application exit");
      check(cfg_rst === 1'b0 && busy === 1'b0, "acquire after reset");
   endtask

   initial begin
      settle(3);
      resetn_in = 1'b1;
      settle(1);
      t_por_exit();
      t_optimal();
      t_long();
      t_short();
      t_app_reset();
      print_verdict();
   end
endmodule
